// ---- cimb_map.svh ----
// Address map, field positions and codes of the CAN interrupt mask bank.
// Assumes inclusion by bare name from the package and from each module.
`ifndef CIMB_MAP_SVH
`define CIMB_MAP_SVH

// Bus widths
`define CIMB_AW            12
`define CIMB_DW            32

// Register byte offsets
`define CIMB_OFS_MODE      12'h000
`define CIMB_OFS_IESET     12'h004
`define CIMB_OFS_IECLR     12'h008
`define CIMB_OFS_IESTATE   12'h00C
`define CIMB_OFS_STATUS    12'h010

// Source bit positions
`define CIMB_BIT_MBOX_LO   0
`define CIMB_BIT_MBOX_HI   7
`define CIMB_BIT_ERRACT    16
`define CIMB_BIT_SLEEP     20
`define CIMB_BIT_WAKE      21
`define CIMB_BIT_STAT_HI   23
`define CIMB_BIT_FAULT_LO  24
`define CIMB_BIT_FAULT_HI  28
`define CIMB_SRC_MASK      32'h1FFF00FF
`define CIMB_RESET_WORD    32'h00000000

// Receive synchronizer select field and codes
`define CIMB_RXS_LSB       24
`define CIMB_RXS_MSB       25
`define CIMB_RXS_LANE      3
`define CIMB_RXS_TWO_POS   2'h0
`define CIMB_RXS_POS_NEG   2'h1
`define CIMB_RXS_ONE_POS   2'h2
`define CIMB_RXS_BYPASS    2'h3

// Bus response codes
`define CIMB_RESP_OKAY     2'h0
`define CIMB_RESP_SLVERR   2'h2

`endif

// ---- cimb_pkg.sv ----
// Types shared by the CAN interrupt mask bank modules.
// Assumes the map header sits in the include path.
`include "cimb_map.svh"

package cimb_pkg;

	typedef enum logic [1:0] {
		CIMB_W_COLLECT = 2'b00,
		CIMB_W_EXEC    = 2'b01,
		CIMB_W_RESP    = 2'b10
	} cimb_wstate_e;

	typedef enum logic [1:0] {
		CIMB_R_IDLE = 2'b00,
		CIMB_R_EXEC = 2'b01,
		CIMB_R_RESP = 2'b10
	} cimb_rstate_e;

	// Register write request, valid for one cycle
	typedef struct packed {
		logic                valid;
		logic [`CIMB_AW-1:0] addr;
		logic [`CIMB_DW-1:0] data;
		logic [3:0]          strb;
	} cimb_wreq_s;

	// Register read request, valid for one cycle
	typedef struct packed {
		logic                valid;
		logic [`CIMB_AW-1:0] addr;
	} cimb_rreq_s;

	// Read answer from the register decode
	typedef struct packed {
		logic [`CIMB_DW-1:0] data;
		logic                err;
	} cimb_rans_s;

	// Byte strobes widened to a bit mask
	function automatic logic [`CIMB_DW-1:0] cimb_lane_mask(input logic [3:0] s);
		cimb_lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

endpackage

// ---- cimb_rx_sync.sv ----
// Selectable conditioning stage for the CAN receive pin.
// Assumes the select comes from a register on clk_sys.
`timescale 1ns/1ps

module cimb_rx_sync
	import cimb_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// Control
	input  wire logic [1:0] sel,
	// Pin and result
	input  wire logic       rx_pin,
	output logic            rx_out
);
	`include "cimb_map.svh"

	logic pos1_r;
	logic pos2_r;
	logic neg2_r;

	// Rising edge stages; idle CAN level is recessive high
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pos1_r <= 1'b1;
			pos2_r <= 1'b1;
		end else begin
			pos1_r <= rx_pin;
			pos2_r <= pos1_r;
		end
	end

	// Falling edge stage trades half a cycle of latency for settling time
	always_ff @(negedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			neg2_r <= 1'b1;
		end else begin
			neg2_r <= pos1_r;
		end
	end

	// Stage choice; debug modes give up metastability protection
	always_comb begin
		case (sel)
			`CIMB_RXS_TWO_POS: rx_out = pos2_r;
			`CIMB_RXS_POS_NEG: rx_out = neg2_r;
			`CIMB_RXS_ONE_POS: rx_out = pos1_r;
			default:           rx_out = rx_pin;
		endcase
	end

endmodule

// ---- cimb_axil_port.sv ----
// AXI4-Lite slave front end: turns bus transfers into one-cycle requests.
// Assumes the register decode answers reads and writes in the request cycle.
`timescale 1ns/1ps

module cimb_axil_port
	import cimb_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rstn,
	// Write address and data
	input  wire logic [`CIMB_AW-1:0] s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [`CIMB_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	// Write response
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// Read address and data
	input  wire logic [`CIMB_AW-1:0] s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [`CIMB_DW-1:0]      s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Register side
	output cimb_wreq_s               wreq,
	input  wire logic                wr_err,
	output cimb_rreq_s               rreq,
	input  cimb_rans_s               rans
);
	`include "cimb_map.svh"

	typedef struct packed {
		cimb_wstate_e        wst;
		logic                have_aw;
		logic                have_w;
		logic [`CIMB_AW-1:0] waddr;
		logic [`CIMB_DW-1:0] wdata;
		logic [3:0]          wstrb;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		cimb_rstate_e        rst;
		logic [`CIMB_AW-1:0] raddr;
		logic                arready;
		logic                rvalid;
		logic [`CIMB_DW-1:0] rdata;
		logic [1:0]          rresp;
	} cimb_port_s;

	cimb_port_s q_r;
	cimb_port_s q_nxt;

	// Both channel sequencers; address and data may come in either order
	always_comb begin
		q_nxt = q_r;
		case (q_r.wst)
			CIMB_W_COLLECT: begin
				if (s_axi_awvalid && q_r.awready) begin
					q_nxt.waddr   = s_axi_awaddr;
					q_nxt.have_aw = 1'b1;
				end
				if (s_axi_wvalid && q_r.wready) begin
					q_nxt.wdata  = s_axi_wdata;
					q_nxt.wstrb  = s_axi_wstrb;
					q_nxt.have_w = 1'b1;
				end
				if (q_nxt.have_aw && q_nxt.have_w) begin
					q_nxt.wst = CIMB_W_EXEC;
				end
			end
			CIMB_W_EXEC: begin
				q_nxt.bvalid = 1'b1;
				q_nxt.bresp  = wr_err ? `CIMB_RESP_SLVERR : `CIMB_RESP_OKAY;
				q_nxt.wst    = CIMB_W_RESP;
			end
			CIMB_W_RESP: begin
				if (s_axi_bready) begin
					q_nxt.bvalid  = 1'b0;
					q_nxt.have_aw = 1'b0;
					q_nxt.have_w  = 1'b0;
					q_nxt.wst     = CIMB_W_COLLECT;
				end
			end
			default: q_nxt.wst = CIMB_W_COLLECT;
		endcase
		case (q_r.rst)
			CIMB_R_IDLE: begin
				if (s_axi_arvalid && q_r.arready) begin
					q_nxt.raddr = s_axi_araddr;
					q_nxt.rst   = CIMB_R_EXEC;
				end
			end
			CIMB_R_EXEC: begin
				q_nxt.rvalid = 1'b1;
				q_nxt.rdata  = rans.data;
				q_nxt.rresp  = rans.err ? `CIMB_RESP_SLVERR : `CIMB_RESP_OKAY;
				q_nxt.rst    = CIMB_R_RESP;
			end
			CIMB_R_RESP: begin
				if (s_axi_rready) begin
					q_nxt.rvalid = 1'b0;
					q_nxt.rst    = CIMB_R_IDLE;
				end
			end
			default: q_nxt.rst = CIMB_R_IDLE;
		endcase
		// Readies are registered from the next state, so they drop on the same edge that takes a channel
		q_nxt.awready = (q_nxt.wst == CIMB_W_COLLECT) && !q_nxt.have_aw;
		q_nxt.wready  = (q_nxt.wst == CIMB_W_COLLECT) && !q_nxt.have_w;
		q_nxt.arready = (q_nxt.rst == CIMB_R_IDLE);
	end

	// State register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// Bus outputs and one-cycle requests
	assign s_axi_awready = q_r.awready;
	assign s_axi_wready  = q_r.wready;
	assign s_axi_bvalid  = q_r.bvalid;
	assign s_axi_bresp   = q_r.bresp;
	assign s_axi_arready = q_r.arready;
	assign s_axi_rvalid  = q_r.rvalid;
	assign s_axi_rdata   = q_r.rdata;
	assign s_axi_rresp   = q_r.rresp;
	assign wreq          = '{valid: (q_r.wst == CIMB_W_EXEC), addr: q_r.waddr, data: q_r.wdata, strb: q_r.wstrb};
	assign rreq          = '{valid: (q_r.rst == CIMB_R_EXEC), addr: q_r.raddr};

endmodule

// ---- cimb_top.sv ----
// Interrupt enable, disable and mask bank of a CAN controller, with
// sticky event status, one interrupt line and receive pin conditioning.
// Assumes source flags come from controller logic on clk_sys.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps

module cimb_top
	import cimb_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rstn,
	// AXI4-Lite write channels
	input  wire logic [`CIMB_AW-1:0] s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [`CIMB_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [`CIMB_AW-1:0] s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [`CIMB_DW-1:0]      s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Controller source flags, same layout as the mask
	input  wire logic [`CIMB_DW-1:0] source_flags,
	// Receive pin and its conditioned copy
	input  wire logic                can_rx_pin,
	output logic                     rx_conditioned,
	// Interrupt request, level
	output logic                     irq
);
	`include "cimb_map.svh"

	typedef struct packed {
		logic [`CIMB_DW-1:0] mask;
		logic [`CIMB_DW-1:0] status;
		logic [1:0]          rxsel;
		logic                irq;
	} cimb_bank_s;

	cimb_bank_s          st_r;
	cimb_bank_s          st_nxt;
	cimb_wreq_s          wreq;
	cimb_rreq_s          rreq;
	cimb_rans_s          rans;
	logic                wr_err;
	logic [`CIMB_DW-1:0] wr_bits;
	logic                sr_read;

	// Bus front end
	cimb_axil_port u_port (
		.clk_sys       (clk_sys),
		.rstn          (rstn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wreq          (wreq),
		.wr_err        (wr_err),
		.rreq          (rreq),
		.rans          (rans)
	);

	// Receive conditioning; the debug codes bypass the usual two-stage guard
	cimb_rx_sync u_rx (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.sel     (st_r.rxsel),
		.rx_pin  (can_rx_pin),
		.rx_out  (rx_conditioned)
	);

	// Written bits after byte strobes, reserved positions dropped
	assign wr_bits = wreq.data & cimb_lane_mask(wreq.strb) & `CIMB_SRC_MASK;
	assign sr_read = rreq.valid && (rreq.addr == `CIMB_OFS_STATUS);

	// Read decode; write-only ports read as zero, unmapped words give SLVERR
	always_comb begin
		rans = '{data: `CIMB_RESET_WORD, err: 1'b0};
		case (rreq.addr)
			`CIMB_OFS_MODE:    rans.data = `CIMB_RESET_WORD;
			`CIMB_OFS_IESET:   rans.data = `CIMB_RESET_WORD;
			`CIMB_OFS_IECLR:   rans.data = `CIMB_RESET_WORD;
			`CIMB_OFS_IESTATE: rans.data = st_r.mask;
			`CIMB_OFS_STATUS:  rans.data = st_r.status;
			default:           rans.err  = 1'b1;
		endcase
	end

	// Write decode; read-only words accept and ignore data
	always_comb begin
		case (wreq.addr)
			`CIMB_OFS_MODE,
			`CIMB_OFS_IESET,
			`CIMB_OFS_IECLR,
			`CIMB_OFS_IESTATE,
			`CIMB_OFS_STATUS: wr_err = 1'b0;
			default:          wr_err = 1'b1;
		endcase
	end

	// Next bank state
	always_comb begin
		st_nxt = st_r;
		// Read clears status, but a flag high in the same cycle sets it again
		st_nxt.status = (sr_read ? `CIMB_RESET_WORD : st_r.status) | (source_flags & `CIMB_SRC_MASK);
		if (wreq.valid) begin
			case (wreq.addr)
				`CIMB_OFS_IESET: st_nxt.mask = st_r.mask | wr_bits;
				`CIMB_OFS_IECLR: st_nxt.mask = st_r.mask & ~wr_bits;
				`CIMB_OFS_MODE: begin
					if (wreq.strb[`CIMB_RXS_LANE]) begin
						st_nxt.rxsel = wreq.data[`CIMB_RXS_MSB:`CIMB_RXS_LSB];
					end
				end
				default: st_nxt.mask = st_r.mask;
			endcase
		end
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);
	end

	// Bank register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign irq = st_r.irq;

	// Checks on the bank behaviour
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence set_write_s;
		wreq.valid && (wreq.addr == `CIMB_OFS_IESET);
	endsequence

	sequence clr_write_s;
		wreq.valid && (wreq.addr == `CIMB_OFS_IECLR);
	endsequence

	mask_set_a: assert property (set_write_s |=> st_r.mask == ($past(st_r.mask) | $past(wr_bits)))
		else $error("enable-set write did not set mask bits");

	mask_clear_a: assert property (clr_write_s |=> st_r.mask == ($past(st_r.mask) & ~$past(wr_bits)))
		else $error("enable-clear write did not clear mask bits");

	mask_read_a: assert property (rreq.valid && rreq.addr == `CIMB_OFS_IESTATE ##1 s_axi_rvalid
		|-> s_axi_rdata == $past(st_r.mask))
		else $error("mask read returned wrong value");

	mbox_map_a: assert property (set_write_s and (wreq.strb[0] && wreq.data[`CIMB_BIT_MBOX_HI:`CIMB_BIT_MBOX_LO] == 8'hFF)
		|=> st_r.mask[`CIMB_BIT_MBOX_HI:`CIMB_BIT_MBOX_LO] == 8'hFF)
		else $error("mailbox enable bits not set");

	status_map_a: assert property (clr_write_s and (wreq.strb[2] && wreq.data[`CIMB_BIT_STAT_HI:`CIMB_BIT_ERRACT] == 8'hFF)
		|=> st_r.mask[`CIMB_BIT_STAT_HI:`CIMB_BIT_ERRACT] == 8'h00)
		else $error("status source enable bits not cleared");

	fault_map_a: assert property (set_write_s and (wreq.strb[3] && wreq.data[`CIMB_BIT_FAULT_HI:`CIMB_BIT_FAULT_LO] == 5'h1F)
		|=> st_r.mask[`CIMB_BIT_FAULT_HI:`CIMB_BIT_FAULT_LO] == 5'h1F)
		else $error("fault enable bits not set");

	wake_own_a: assert property (set_write_s and (wreq.strb[2] && wreq.data[`CIMB_BIT_WAKE] && !wreq.data[`CIMB_BIT_SLEEP])
		|=> st_r.mask[`CIMB_BIT_WAKE] && st_r.mask[`CIMB_BIT_SLEEP] == $past(st_r.mask[`CIMB_BIT_SLEEP]))
		else $error("wake-up enable disturbed sleep enable");

	rx_select_a: assert property (wreq.valid && wreq.addr == `CIMB_OFS_MODE && wreq.strb[`CIMB_RXS_LANE]
		|=> st_r.rxsel == $past(wreq.data[`CIMB_RXS_MSB:`CIMB_RXS_LSB]))
		else $error("rx select not loaded");

	rx_single_a: assert property (st_r.rxsel == `CIMB_RXS_ONE_POS && $past(st_r.rxsel) == `CIMB_RXS_ONE_POS
		|-> rx_conditioned == $past(can_rx_pin))
		else $error("single stage rx path wrong");

	mode_hidden_a: assert property (rreq.valid && rreq.addr == `CIMB_OFS_MODE
		|=> s_axi_rdata[`CIMB_RXS_MSB:`CIMB_RXS_LSB] == 2'h0)
		else $error("rx select visible on read");

	irq_level_a: assert property ((|(source_flags & st_r.mask & `CIMB_SRC_MASK)) && !wreq.valid |=> irq)
		else $error("interrupt missing for enabled flag");

	irq_quiet_a: assert property (irq |-> |(st_r.status & st_r.mask))
		else $error("interrupt without enabled status");

	rsvd_zero_a: assert property ((st_r.mask & ~`CIMB_SRC_MASK) == `CIMB_RESET_WORD)
		else $error("reserved mask bit set");

	// Mode writes are the only way to move the rx select
	sequence mode_write_s;
		wreq.valid && (wreq.addr == `CIMB_OFS_MODE);
	endsequence

	// Mask only moves on a port write, so stray bus traffic cannot disturb it
	mask_hold_a: assert property (!wreq.valid |=> st_r.mask == $past(st_r.mask))
		else $error("mask changed without a write");

	mbox_clear_a: assert property (clr_write_s and (wreq.strb[0] && wreq.data[`CIMB_BIT_MBOX_HI:`CIMB_BIT_MBOX_LO] == 8'hFF)
		|=> st_r.mask[`CIMB_BIT_MBOX_HI:`CIMB_BIT_MBOX_LO] == 8'h00)
		else $error("mailbox enable bits not cleared");

	status_set_a: assert property (set_write_s and (wreq.strb[2] && wreq.data[`CIMB_BIT_STAT_HI:`CIMB_BIT_ERRACT] == 8'hFF)
		|=> st_r.mask[`CIMB_BIT_STAT_HI:`CIMB_BIT_ERRACT] == 8'hFF)
		else $error("status source enable bits not set");

	fault_clear_a: assert property (clr_write_s and (wreq.strb[3] && wreq.data[`CIMB_BIT_FAULT_HI:`CIMB_BIT_FAULT_LO] == 5'h1F)
		|=> st_r.mask[`CIMB_BIT_FAULT_HI:`CIMB_BIT_FAULT_LO] == 5'h00)
		else $error("fault enable bits not cleared");

	wake_clear_a: assert property (clr_write_s and (wreq.strb[2] && wreq.data[`CIMB_BIT_WAKE] && !wreq.data[`CIMB_BIT_SLEEP])
		|=> !st_r.mask[`CIMB_BIT_WAKE] && st_r.mask[`CIMB_BIT_SLEEP] == $past(st_r.mask[`CIMB_BIT_SLEEP]))
		else $error("wake-up disable disturbed sleep enable");

	// Each select code against the pin history; the stages run whatever the select
	rx_double_a: assert property (st_r.rxsel == `CIMB_RXS_TWO_POS
		|-> rx_conditioned == $past(can_rx_pin, 2))
		else $error("two stage rx path wrong");

	rx_posneg_a: assert property (st_r.rxsel == `CIMB_RXS_POS_NEG
		|-> rx_conditioned == $past(can_rx_pin))
		else $error("rising then falling rx path wrong");

	rx_bypass_a: assert property (st_r.rxsel == `CIMB_RXS_BYPASS
		|-> rx_conditioned == can_rx_pin)
		else $error("bypass rx path wrong");

	// Select is held between mode writes, so a debug setting never drifts
	rsel_hold_a: assert property (not mode_write_s |=> st_r.rxsel == $past(st_r.rxsel))
		else $error("rx select changed without a mode write");

	// Status is sticky until a status read, and a read keeps flags of that cycle
	status_sticky_a: assert property (!sr_read |=> (st_r.status & $past(st_r.status)) == $past(st_r.status))
		else $error("status bit lost without a read");

	status_clear_a: assert property (sr_read |=> st_r.status == ($past(source_flags) & `CIMB_SRC_MASK))
		else $error("status read did not clear");

	status_rsvd_a: assert property ((st_r.status & ~`CIMB_SRC_MASK) == `CIMB_RESET_WORD)
		else $error("reserved status bit set");

	irq_off_a: assert property (!(|(source_flags & st_r.mask)) && sr_read && !wreq.valid |=> !irq)
		else $error("interrupt stayed up after status read");

endmodule

// ---- cimb_testbench.sv ----
// Self-checking testbench of the CAN interrupt mask bank top level.
// Assumes the map header and the package are compiled first; a single
// 40 MHz clock drives everything, with the bus driven as an AXI4-Lite master.
`timescale 1ns/1ps
`include "cimb_map.svh"

module testbench
	import cimb_pkg::*;
;
	// Clock, reset and design ports
	logic        clk_sys;
	logic        rstn;
	logic [11:0] s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [11:0] s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic [31:0] source_flags;
	logic        can_rx_pin;
	logic        rx_conditioned;
	logic        irq;
	int          fail_count;
	int          num_checks;
	logic [31:0] src_bits;

	cimb_top dut (
		.clk_sys        (clk_sys),
		.rstn           (rstn),
		.s_axi_awaddr   (s_axi_awaddr),
		.s_axi_awvalid  (s_axi_awvalid),
		.s_axi_awready  (s_axi_awready),
		.s_axi_wdata    (s_axi_wdata),
		.s_axi_wstrb    (s_axi_wstrb),
		.s_axi_wvalid   (s_axi_wvalid),
		.s_axi_wready   (s_axi_wready),
		.s_axi_bresp    (s_axi_bresp),
		.s_axi_bvalid   (s_axi_bvalid),
		.s_axi_bready   (s_axi_bready),
		.s_axi_araddr   (s_axi_araddr),
		.s_axi_arvalid  (s_axi_arvalid),
		.s_axi_arready  (s_axi_arready),
		.s_axi_rdata    (s_axi_rdata),
		.s_axi_rresp    (s_axi_rresp),
		.s_axi_rvalid   (s_axi_rvalid),
		.s_axi_rready   (s_axi_rready),
		.source_flags   (source_flags),
		.can_rx_pin     (can_rx_pin),
		.rx_conditioned (rx_conditioned),
		.irq            (irq)
	);

	// 25 ns system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Verdict, printed once at the single exit point
	task automatic end_of_test();
		if (fail_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Compare with case equality so an unknown never matches
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// A hung handshake counts as a mismatch and ends the run
	task automatic timeout();
		fail_count++;
		$display("ERROR t=%0t got=%h exp=%h", $time, 32'h00000000, 32'h00000001);
		end_of_test();
	endtask

	// Bus write: address and data offered together, each released when taken
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int   n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				check({30'h0, s_axi_bresp}, {30'h0, er});
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end else if (n > 50) begin
				timeout();
			end
		end
	endtask

	// Bus read: rready held until the answer is sampled
	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int   n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end else if (n > 50) begin
				timeout();
			end
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		axi_write(a, d, 4'hF, `CIMB_RESP_OKAY);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(a, d, r);
		check(d, e);
		check({30'h0, r}, {30'h0, `CIMB_RESP_OKAY});
	endtask

	// One-cycle flag pulse, then time for status and irq to settle
	task automatic pulse(input logic [31:0] f);
		@(posedge clk_sys);
		source_flags <= f;
		@(posedge clk_sys);
		source_flags <= 32'h00000000;
		repeat (3) @(posedge clk_sys);
	endtask

	// Everything idle and cleared straight after reset
	task automatic t_reset();
		check({31'h0, irq}, 32'h00000000);
		rd_chk(`CIMB_OFS_IESTATE, 32'h00000000);
		rd_chk(`CIMB_OFS_STATUS, 32'h00000000);
	endtask

	// Set-only and clear-only semantics, strobes, reserved bits, bus errors
	task automatic t_set_clear();
		logic [31:0] d;
		logic [1:0]  r;
		wr(`CIMB_OFS_IESET, 32'h000000F0);
		wr(`CIMB_OFS_IESET, 32'h0000000F);
		rd_chk(`CIMB_OFS_IESTATE, 32'h000000FF);
		wr(`CIMB_OFS_IECLR, 32'h0000003C);
		rd_chk(`CIMB_OFS_IESTATE, 32'h000000C3);
		axi_write(`CIMB_OFS_IESTATE, 32'hFFFFFFFF, 4'hF, `CIMB_RESP_OKAY);
		rd_chk(`CIMB_OFS_IESTATE, 32'h000000C3);
		wr(`CIMB_OFS_IESET, 32'hFFFFFFFF);
		rd_chk(`CIMB_OFS_IESTATE, src_bits);
		wr(`CIMB_OFS_IECLR, 32'hFFFFFFFF);
		axi_write(`CIMB_OFS_IESET, 32'hFFFFFFFF, 4'h1, `CIMB_RESP_OKAY);
		rd_chk(`CIMB_OFS_IESTATE, 32'h000000FF);
		rd_chk(`CIMB_OFS_IESET, 32'h00000000);
		rd_chk(`CIMB_OFS_IECLR, 32'h00000000);
		axi_read(12'h014, d, r);
		check(d, 32'h00000000);
		check({30'h0, r}, {30'h0, `CIMB_RESP_SLVERR});
		axi_write(12'h100, 32'hFFFFFFFF, 4'hF, `CIMB_RESP_SLVERR);
		rd_chk(`CIMB_OFS_IESTATE, 32'h000000FF);
		wr(`CIMB_OFS_IECLR, 32'hFFFFFFFF);
	endtask

	// Each source alone: its own mask bit gates only its own flag
	task automatic t_per_source();
		logic [31:0] b;
		for (int i = 0; i < 32; i++) begin
			if (src_bits[i]) begin
				b = 32'h00000001 << i;
				wr(`CIMB_OFS_IESET, b);
				rd_chk(`CIMB_OFS_IESTATE, b);
				pulse(src_bits & ~b);
				check({31'h0, irq}, 32'h00000000);
				pulse(b);
				check({31'h0, irq}, 32'h00000001);
				rd_chk(`CIMB_OFS_STATUS, src_bits);
				repeat (2) @(posedge clk_sys);
				check({31'h0, irq}, 32'h00000000);
				wr(`CIMB_OFS_IECLR, b);
			end
		end
		rd_chk(`CIMB_OFS_IESTATE, 32'h00000000);
	endtask

	// Pending events stay silent until enabled, then raise irq at once
	task automatic t_mask_gate();
		pulse(32'hFFFFFFFF);
		check({31'h0, irq}, 32'h00000000);
		wr(`CIMB_OFS_IESET, 32'h00200000);
		@(posedge clk_sys);
		check({31'h0, irq}, 32'h00000001);
		rd_chk(`CIMB_OFS_STATUS, src_bits);
		repeat (2) @(posedge clk_sys);
		check({31'h0, irq}, 32'h00000000);
		wr(`CIMB_OFS_IECLR, 32'hFFFFFFFF);
	endtask

	// Receive path latency per select code, in half cycles
	task automatic t_rx_select();
		int   lat_tab [4];
		int   lat;
		logic p;
		lat_tab = '{4, 3, 2, 0};
		for (int c = 0; c < 4; c++) begin
			wr(`CIMB_OFS_MODE, {6'h00, 2'(c), 24'h000000});
			rd_chk(`CIMB_OFS_MODE, 32'h00000000);
			repeat (4) @(posedge clk_sys);
			lat = lat_tab[c];
			p = rx_conditioned;
			@(posedge clk_sys);
			can_rx_pin <= ~p;
			#1 check({31'h0, rx_conditioned}, {31'h0, (lat <= 0) ? ~p : p});
			@(posedge clk_sys);
			#1 check({31'h0, rx_conditioned}, {31'h0, (lat <= 2) ? ~p : p});
			@(negedge clk_sys);
			#1 check({31'h0, rx_conditioned}, {31'h0, (lat <= 3) ? ~p : p});
			@(posedge clk_sys);
			#1 check({31'h0, rx_conditioned}, {31'h0, ~p});
		end
	endtask

	// Main sequence
	initial begin
		fail_count = 0;
		num_checks = 0;
		src_bits = `CIMB_SRC_MASK;
		rstn = 1'b0;
		s_axi_awaddr = 12'h000;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 12'h000;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		source_flags = 32'h00000000;
		can_rx_pin = 1'b1;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t_reset();
		t_set_clear();
		t_per_source();
		t_mask_gate();
		t_rx_select();
		end_of_test();
	end

endmodule
